//--- design/cms_lowest_first.sv
// Picks the lowest set bit of a request vector.
// Assumes requests come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cms_lowest_first #(
	parameter int N = 15,
	parameter int W = 4
) (
	input  wire logic [N-1:0] request,
	output logic              found,
	output logic [W-1:0]      index
);
	always_comb begin
		found = 1'b0;
		index = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (request[i]) begin
				found = 1'b1;
				index = W'(i);
			end
		end
	end
endmodule : cms_lowest_first
`default_nettype wire

//--- design/cms_obj_status.sv
// Per-object status flags and standard identifier tags on the SFR bus.
// Assumes the protocol engine and page register run on clk_sys.
// Functional notes
// - Status byte of the page-selected object sits at address B2h.
// - Transmit-done flag, bit 6, sets when an enabled transmission completes.
// - Among pending transmitters the lowest index object is sent first.
// - Receive-done flag, bit 5, sets when an enabled reception completes.
// - On several receive hits only the lowest index object is updated.
// - Bit-mismatch flag, bit 4, sets on readback difference, transmit only.
// - No mismatch for dominant readback in arbitration, ack slot, error frame.
// - Any newly set transmit, receive or error flag raises an event.
// - Tag register at BCh holds identifier bits 10 to 3, MSB first.
// - Tag register at BDh holds identifier bits 2 to 0 in bits 7-5.
// - Register at BEh is reserved in standard format.
// - Tag registers are not initialised at reset; software writes them.
// - Standard tag layout applies while the extended-format select is 0.
`timescale 1ns/1ps
`default_nettype none
module cms_obj_status #(
	parameter int NUM_OBJ = cms_pkg::NUM_OBJ,
	parameter int OBJ_W   = cms_pkg::OBJ_W,
	parameter int LEN_W   = cms_pkg::LEN_W
) (
	input  wire logic                     clk_sys,
	input  wire logic                     srst,
	input  wire logic [7:0]               sfrAddr,
	input  wire logic                     sfrWrEn,
	input  wire logic                     sfrRdEn,
	input  wire logic [7:0]               sfrWrData,
	output logic      [7:0]               sfrRdData,
	input  wire logic [OBJ_W-1:0]         objectSelect,
	input  wire logic [NUM_OBJ-1:0]       extendedFormatSelect,
	input  wire logic [NUM_OBJ*LEN_W-1:0] lengthCode,
	input  wire logic [NUM_OBJ-1:0]       txPending,
	output logic                          txFound,
	output logic      [OBJ_W-1:0]         txObject,
	input  wire logic                     txDone,
	input  wire logic [NUM_OBJ-1:0]       rxHit,
	input  wire logic                     rxDone,
	input  wire logic [LEN_W-1:0]         rxLength,
	output logic                          rxFound,
	output logic      [OBJ_W-1:0]         rxObject,
	input  wire logic [OBJ_W-1:0]         errObject,
	input  wire logic                     txActive,
	input  wire logic                     bitSample,
	input  wire logic                     drivenLevel,
	input  wire logic                     busLevel,
	input  wire logic                     inArbitration,
	input  wire logic                     inAckSlot,
	input  wire logic                     inErrorFrame,
	input  wire logic                     stuffFault,
	input  wire logic                     checksumFault,
	input  wire logic                     formFault,
	input  wire logic                     ackMissing,
	output logic                          statusEvent
);
	// ****************************************************************
	// Priority selection
	// ****************************************************************
	cms_lowest_first #(.N(NUM_OBJ), .W(OBJ_W)) txPick (
		.request (txPending),
		.found   (txFound),
		.index   (txObject)
	);

	cms_lowest_first #(.N(NUM_OBJ), .W(OBJ_W)) rxPick (
		.request (rxHit),
		.found   (rxFound),
		.index   (rxObject)
	);

	// ****************************************************************
	// Storage
	// ****************************************************************
	logic [7:0] status     [NUM_OBJ];
	logic [7:0] next_status[NUM_OBJ];
	logic [7:0] tagHigh    [NUM_OBJ];
	logic [7:0] tagLow     [NUM_OBJ];
	logic [7:0] tagExtra   [NUM_OBJ];
	logic [7:0] next_tagHigh;
	logic [7:0] next_tagLow;
	logic [7:0] next_tagExtra;
	logic [7:0] next_sfrRdData;
	logic       next_statusEvent;
	logic       selValid;
	logic       bitMismatch;
	logic       mismatchExcused;

	function automatic logic [LEN_W-1:0] progLength(input int i);
		progLength = lengthCode[i*LEN_W +: LEN_W];
	endfunction : progLength

	function automatic logic writeTo(input logic [7:0] addr);
		writeTo = sfrWrEn && selValid && (sfrAddr == addr);
	endfunction : writeTo

	assign selValid = (int'(objectSelect) < NUM_OBJ);

	// A recessive bit overwritten by a dominant one is legal in arbitration
	// and the ack slot, and error frames may be overdriven by other nodes.
	assign mismatchExcused = inErrorFrame ||
		((drivenLevel == cms_pkg::LEVEL_RECESSIVE) &&
		 (inArbitration || inAckSlot));
	assign bitMismatch = txActive && bitSample &&
		(drivenLevel != busLevel) && !mismatchExcused;

	// ****************************************************************
	// Next values
	// ****************************************************************
	always_comb begin
		logic [7:0] setBits;
		logic [7:0] base;
		logic       anySet;
		setBits = '0;
		base = '0;
		anySet = 1'b0;
		for (int i = 0; i < NUM_OBJ; i++) begin
			setBits = '0;
			if (txDone && txFound && (int'(txObject) == i)) begin
				setBits[cms_pkg::BIT_TX_DONE] = 1'b1;
			end
			if (rxDone && rxFound && (int'(rxObject) == i)) begin
				setBits[cms_pkg::BIT_RX_DONE] = 1'b1;
				if (rxLength != progLength(i)) begin
					setBits[cms_pkg::BIT_LEN_WARN] = 1'b1;
				end
			end
			if (int'(errObject) == i) begin
				setBits[cms_pkg::BIT_MISMATCH] = bitMismatch;
				setBits[cms_pkg::BIT_STUFF]    = stuffFault;
				setBits[cms_pkg::BIT_CHECKSUM] = checksumFault;
				setBits[cms_pkg::BIT_FORM]     = formFault;
				setBits[cms_pkg::BIT_ACK]      = ackMissing;
			end
			base = status[i];
			if (writeTo(cms_pkg::ADDR_STATUS) &&
			    (int'(objectSelect) == i)) begin
				base = sfrWrData;
			end
			// Hardware set wins over a software clear in the same cycle.
			next_status[i] = base | setBits;
			if (|(setBits & ~status[i])) begin
				anySet = 1'b1;
			end
		end
		next_statusEvent = anySet;
	end

	always_comb begin
		next_tagHigh  = selValid ? tagHigh[objectSelect]  : '0;
		next_tagLow   = selValid ? tagLow[objectSelect]   : '0;
		next_tagExtra = selValid ? tagExtra[objectSelect] : '0;
		if (writeTo(cms_pkg::ADDR_TAG_HIGH)) begin
			next_tagHigh = sfrWrData;
		end
		if (writeTo(cms_pkg::ADDR_TAG_LOW)) begin
			next_tagLow = sfrWrData;
		end
		if (writeTo(cms_pkg::ADDR_TAG_UNUSED)) begin
			next_tagExtra = sfrWrData;
		end
	end

	always_comb begin
		next_sfrRdData = cms_pkg::READ_FILL;
		if (sfrRdEn && selValid) begin
			unique case (sfrAddr)
				cms_pkg::ADDR_STATUS: begin
					next_sfrRdData = status[objectSelect];
				end
				cms_pkg::ADDR_TAG_HIGH: begin
					next_sfrRdData = tagHigh[objectSelect];
				end
				cms_pkg::ADDR_TAG_LOW: begin
					// Reserved low bits read as zero in standard format.
					next_sfrRdData = extendedFormatSelect[objectSelect] ?
						tagLow[objectSelect] :
						(tagLow[objectSelect] &
						 cms_pkg::TAG_LOW_STD_MASK);
				end
				cms_pkg::ADDR_TAG_UNUSED: begin
					next_sfrRdData = extendedFormatSelect[objectSelect] ?
						tagExtra[objectSelect] :
						cms_pkg::READ_FILL;
				end
				default: begin
					next_sfrRdData = cms_pkg::READ_FILL;
				end
			endcase
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < NUM_OBJ; i++) begin
				status[i] <= cms_pkg::STATUS_RESET;
			end
			sfrRdData   <= cms_pkg::READ_FILL;
			statusEvent <= 1'b0;
		end else begin
			for (int i = 0; i < NUM_OBJ; i++) begin
				status[i] <= next_status[i];
			end
			sfrRdData   <= next_sfrRdData;
			statusEvent <= next_statusEvent;
		end
	end

	// Tags carry no reset so that they map onto plain storage cells.
	always_ff @(posedge clk_sys) begin
		if (selValid) begin
			tagHigh[objectSelect]  <= next_tagHigh;
			tagLow[objectSelect]   <= next_tagLow;
			tagExtra[objectSelect] <= next_tagExtra;
		end
	end
endmodule : cms_obj_status
`default_nettype wire

//--- design/cms_pkg.sv
// Constants shared by the message object status and identifier tag block.
// Assumes an 8-bit special-function-register bus with byte addresses.
package cms_pkg;
	localparam int         NUM_OBJ        = 15;
	localparam int         OBJ_W          = 4;
	localparam int         LEN_W          = 4;
	localparam logic [7:0] ADDR_STATUS    = 8'hB2;
	localparam logic [7:0] ADDR_TAG_HIGH  = 8'hBC;
	localparam logic [7:0] ADDR_TAG_LOW   = 8'hBD;
	localparam logic [7:0] ADDR_TAG_UNUSED = 8'hBE;
	localparam int         BIT_LEN_WARN   = 7;
	localparam int         BIT_TX_DONE    = 6;
	localparam int         BIT_RX_DONE    = 5;
	localparam int         BIT_MISMATCH   = 4;
	localparam int         BIT_STUFF      = 3;
	localparam int         BIT_CHECKSUM   = 2;
	localparam int         BIT_FORM       = 1;
	localparam int         BIT_ACK        = 0;
	localparam logic [7:0] STATUS_RESET   = 8'h00;
	localparam logic [7:0] TAG_LOW_STD_MASK = 8'hE0;
	localparam logic [7:0] READ_FILL      = 8'h00;
	localparam logic       LEVEL_RECESSIVE = 1'b1;
endpackage : cms_pkg

//--- verification/cms_can_node.sv
// Other nodes on the shared bus, seen as one wired-AND line.
// Assumes the bench says when the far nodes send a dominant bit.
`timescale 1ns/1ps
`default_nettype none
module cms_can_node (
	input  wire logic drivenLevel,
	input  wire logic pullDom,
	output logic      busLevel
);
	// Dominant wins the line, so a recessive bit can read back dominant.
	assign busLevel = drivenLevel & ~pullDom;
endmodule : cms_can_node
`default_nettype wire

//--- verification/cms_obj_status_props.sv
// Port assertions for the object status block.
// Assumes cms_pkg is compiled first; bound to every design instance.
`timescale 1ns/1ps
`default_nettype none
module cms_obj_status_props #(
	parameter int NUM_OBJ = 15,
	parameter int OBJ_W   = 4
) (
	input wire logic               clk_sys,
	input wire logic               srst,
	input wire logic [7:0]         sfrAddr,
	input wire logic               sfrRdEn,
	input wire logic [7:0]         sfrRdData,
	input wire logic [OBJ_W-1:0]   objectSelect,
	input wire logic [NUM_OBJ-1:0] extendedFormatSelect,
	input wire logic [NUM_OBJ-1:0] txPending,
	input wire logic               txFound,
	input wire logic [OBJ_W-1:0]   txObject,
	input wire logic [NUM_OBJ-1:0] rxHit,
	input wire logic               rxFound,
	input wire logic [OBJ_W-1:0]   rxObject,
	input wire logic               statusEvent
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	logic stdSel;
	assign stdSel = sfrRdEn && (int'(objectSelect) < NUM_OBJ)
		&& !extendedFormatSelect[objectSelect];
	rd_idle_zero_a: assert property (!$past(sfrRdEn) |-> sfrRdData == 0)
		else $error("read data not idle");
	bad_addr_zero_a: assert property (sfrRdEn && sfrAddr != 8'hB2
		&& (sfrAddr < 8'hBC || sfrAddr > 8'hBE) |=> sfrRdData == 0)
		else $error("unmapped read not zero");
	no_object_zero_a: assert property (sfrRdEn && objectSelect == 15
		|=> sfrRdData == 0) else $error("object 15 read not zero");
	tx_found_a: assert property (txFound == (|txPending))
		else $error("tx found wrong");
	tx_lowest_a: assert property (txFound |-> txPending[txObject] &&
		(txPending & ~({NUM_OBJ{1'b1}} << txObject)) == '0)
		else $error("tx not lowest");
	rx_found_a: assert property (rxFound == (|rxHit))
		else $error("rx found wrong");
	rx_lowest_a: assert property (rxFound |-> rxHit[rxObject] &&
		(rxHit & ~({NUM_OBJ{1'b1}} << rxObject)) == '0)
		else $error("rx not lowest");
	tag_low_mask_a: assert property (stdSel && sfrAddr == 8'hBD
		|=> sfrRdData[4:0] == 0) else $error("tag low reserved bits");
	tag_unused_a: assert property (stdSel && sfrAddr == 8'hBE
		|=> sfrRdData == 0) else $error("tag unused not zero");
	cover property (stdSel && sfrAddr == 8'hBD);
	cover property (txFound && rxFound);
	cover property (statusEvent);
endmodule : cms_obj_status_props
bind cms_obj_status cms_obj_status_props #(.NUM_OBJ(NUM_OBJ), .OBJ_W(OBJ_W))
	cms_obj_status_props_inst (
	.clk_sys              (clk_sys),
	.srst                 (srst),
	.sfrAddr              (sfrAddr),
	.sfrRdEn              (sfrRdEn),
	.sfrRdData            (sfrRdData),
	.objectSelect         (objectSelect),
	.extendedFormatSelect (extendedFormatSelect),
	.txPending            (txPending),
	.txFound              (txFound),
	.txObject             (txObject),
	.rxHit                (rxHit),
	.rxFound              (rxFound),
	.rxObject             (rxObject),
	.statusEvent          (statusEvent)
);
`default_nettype wire

//--- verification/test_can_msg_object_status_and_std_id.sv
// Self-checking bench for the object status and tag block.
// Assumes the design, its package, checker and node model compile first.
`timescale 1ns/1ps
`default_nettype none
module test_can_msg_object_status_and_std_id;
	logic clk_sys = 0, srst = 1, sfrWrEn = 0, sfrRdEn = 0, pullDom = 0;
	logic [7:0] sfrAddr = 0, sfrWrData = 0, sfrRdData, m;
	logic [3:0] objectSelect = 0, errObject = 9, rxLength = 0;
	logic [3:0] txObject, rxObject;
	logic [14:0] extendedFormatSelect = 0, txPending = 0, rxHit = 0, v;
	logic [59:0] lengthCode = 0;
	logic [6:0] pls = 0;
	logic [10:0] id;
	logic [3:0] md [5] = '{4'h9, 4'h5, 4'h3, 4'h0, 4'h1};
	logic txDone, rxDone, bitSample, stuffFault, checksumFault, formFault;
	logic ackMissing, txFound, rxFound, statusEvent, busLevel;
	logic txActive = 0, drivenLevel = 1, inArbitration = 0, inAckSlot = 0;
	logic inErrorFrame = 0;
	int mismatches = 0, checks = 0, st[15], k;
	assign {txDone, rxDone, bitSample, stuffFault, checksumFault, formFault,
		ackMissing} = pls;
	always #2 clk_sys = ~clk_sys;
	cms_obj_status cms_obj_status_inst (
		.clk_sys              (clk_sys),
		.srst                 (srst),
		.sfrAddr              (sfrAddr),
		.sfrWrEn              (sfrWrEn),
		.sfrRdEn              (sfrRdEn),
		.sfrWrData            (sfrWrData),
		.sfrRdData            (sfrRdData),
		.objectSelect         (objectSelect),
		.extendedFormatSelect (extendedFormatSelect),
		.lengthCode           (lengthCode),
		.txPending            (txPending),
		.txFound              (txFound),
		.txObject             (txObject),
		.txDone               (txDone),
		.rxHit                (rxHit),
		.rxDone               (rxDone),
		.rxLength             (rxLength),
		.rxFound              (rxFound),
		.rxObject             (rxObject),
		.errObject            (errObject),
		.txActive             (txActive),
		.bitSample            (bitSample),
		.drivenLevel          (drivenLevel),
		.busLevel             (busLevel),
		.inArbitration        (inArbitration),
		.inAckSlot            (inAckSlot),
		.inErrorFrame         (inErrorFrame),
		.stuffFault           (stuffFault),
		.checksumFault        (checksumFault),
		.formFault            (formFault),
		.ackMissing           (ackMissing),
		.statusEvent          (statusEvent)
	);
	cms_can_node cms_can_node_inst (.drivenLevel, .pullDom, .busLevel);
	task print_verdict;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : print_verdict
	task chk(string n, logic [7:0] e, logic [7:0] g);
		checks++;
		if (e !== g) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task acc(logic w, int o, logic [7:0] a, logic [7:0] d);
		@(posedge clk_sys);
		objectSelect <= 4'(o);
		sfrAddr <= a;
		sfrWrData <= d;
		sfrWrEn <= w;
		sfrRdEn <= !w;
		@(posedge clk_sys);
		sfrWrEn <= 0;
		sfrRdEn <= 0;
		@(negedge clk_sys);
		if (!w) chk("read", d, sfrRdData);
	endtask : acc
	task pulse(int i);
		@(posedge clk_sys);
		pls[i] <= 1;
		@(posedge clk_sys);
		pls <= 0;
		@(negedge clk_sys);
	endtask : pulse
	// A hang is cut after about one hundred and eighty times the expected run.
	initial begin
		#100000;
		mismatches++;
		print_verdict();
	end
	initial begin
		k = $urandom(32'h50c3_ea58);
		repeat (6) @(posedge clk_sys);
		srst <= 0;
		for (int i = 0; i < 15; i++) begin
			st[i] = 0;
			acc(0, i, 8'hB2, 0);
		end
		id = 11'($urandom);
		acc(1, 3, 8'hBC, id[10:3]);
		acc(1, 3, 8'hBD, {id[2:0], 5'h1F});
		acc(0, 3, 8'hBC, id[10:3]);
		acc(0, 3, 8'hBD, {id[2:0], 5'h00});
		acc(0, 3, 8'hBE, 0);
		acc(0, 15, 8'hBC, 0);
		acc(0, 3, 8'hB5, 0);
		@(posedge clk_sys);
		extendedFormatSelect <= 15'h0008;
		acc(1, 3, 8'hBD, 8'h5B);
		acc(0, 3, 8'hBD, 8'h5B);
		acc(1, 2, 8'hB2, 8'hA5);
		st[2] = 8'hA5;
		acc(0, 2, 8'hB2, 8'hA5);
		for (int j = 0; j < 6; j++) begin
			@(posedge clk_sys);
			v = 15'($urandom) | 15'h4000;
			txPending <= v;
			rxHit <= v;
			rxLength <= 4'($urandom);
			lengthCode <= 60'({$urandom, $urandom});
			@(negedge clk_sys);
			for (k = 0; !v[k]; k++);
			chk("txObject", 8'(k), {4'h0, txObject});
			chk("rxObject", 8'(k), {4'h0, rxObject});
			chk("txFound", 8'h01, {7'h0, txFound});
			chk("rxFound", 8'h01, {7'h0, rxFound});
			m = j < 3 ? 8'h40 :
				8'h20 | (rxLength != lengthCode[4*k+:4] ? 8'h80 : 8'h00);
			pulse(j < 3 ? 6 : 5);
			chk("event", 8'(|(m & ~st[k])), {7'h0, statusEvent});
			st[k] |= m;
			acc(0, k, 8'hB2, st[k]);
		end
		@(posedge clk_sys);
		pullDom <= 1;
		foreach (md[j]) begin
			@(posedge clk_sys);
			{inArbitration, inAckSlot, inErrorFrame, txActive} <= md[j];
			pulse(4);
			if (j == 4) st[9] |= 8'h10;
			acc(0, 9, 8'hB2, st[9]);
		end
		for (int i = 0; i < 4; i++) begin
			pulse(i);
			st[9] |= 1 << i;
			acc(0, 9, 8'hB2, st[9]);
		end
		// A second reset clears the status bytes but must leave tags alone.
		@(posedge clk_sys);
		srst <= 1;
		txPending <= 0;
		rxHit <= 0;
		repeat (2) @(posedge clk_sys);
		srst <= 0;
		@(negedge clk_sys);
		chk("txFound", 8'h00, {7'h0, txFound});
		chk("rxFound", 8'h00, {7'h0, rxFound});
		chk("event", 8'h00, {7'h0, statusEvent});
		acc(0, 9, 8'hB2, 0);
		acc(0, 3, 8'hBC, id[10:3]);
		print_verdict();
	end
endmodule : test_can_msg_object_status_and_std_id
`default_nettype wire
